// file: ckl_cfg.svh
`ifndef CKL_CFG_SVH
`define CKL_CFG_SVH

`define CKL_ADDR_W 16
`define CKL_OFS_ENABLE 16'h0500
`define CKL_OFS_KEY_SEL 16'h1A38
`define CKL_OFS_KEY_LOCK 16'h1A4C
`define CKL_OFS_ROOT0 16'h1A50
`define CKL_OFS_ROOT1 16'h1A54
`define CKL_OFS_ROOT2 16'h1A58
`define CKL_OFS_ROOT3 16'h1A5C
`define CKL_OFS_LCS 16'h1A60
`define CKL_WORD_STEP 16'h0004

`define CKL_KEY_WORDS 4
`define CKL_KEY_W 128
`define CKL_ENABLE_POS 0
`define CKL_LOCK_POS 0
`define CKL_RETAINED_POS 0
`define CKL_SEL_W 2
`define CKL_LCS_W 3
`define CKL_LCS_VALID_POS 8

`define CKL_SEL_ROOT 2'h0
`define CKL_SEL_SECONDARY 2'h1
`define CKL_LCS_DEBUG 3'h0
`define CKL_LCS_SECURE 3'h2

`define CKL_RST_ENABLE 1'h0
`define CKL_RST_SEL 2'h0
`define CKL_RST_LCS 3'h2

`endif

// file: ckl_pkg.sv
`default_nettype none
`include "ckl_cfg.svh"

package ckl_pkg;

   typedef struct packed {
      logic [`CKL_ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ckl_bus_req_t;

   typedef struct packed {
      logic enable;
      logic [`CKL_SEL_W-1:0] key_sel;
      logic lock;
   } ckl_key_cfg_t;

   typedef struct packed {
      logic enable;
      logic [`CKL_SEL_W-1:0] key_sel;
      logic lock_set;
      logic lock_used;
      logic [`CKL_KEY_WORDS-1:0][31:0] root_key;
      logic [`CKL_KEY_WORDS-1:0] word_written;
      logic retained;
      logic [`CKL_LCS_W-1:0] lifecycle_state;
      logic lcs_written;
      logic [31:0] rdata;
   } ckl_regs_state_t;

   typedef struct packed {
      logic [`CKL_KEY_W-1:0] key;
   } ckl_mux_state_t;

endpackage

`default_nettype wire

// file: ckl_key_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

module ckl_key_mux (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire ckl_pkg::ckl_key_cfg_t cfg,
   input wire logic [`CKL_KEY_W-1:0] root_key,
   input wire logic [`CKL_KEY_W-1:0] secondary_hw_key,
   output logic [`CKL_KEY_W-1:0] aes_key
);

   ckl_pkg::ckl_mux_state_t m;
   ckl_pkg::ckl_mux_state_t next_m;

   // The key is registered so that the engine never sees a glitch while
   // software rewrites the select or the lock.
   always_comb begin
      next_m = m;
      if (!cfg.enable) begin
         next_m.key = '0;
      end else if (cfg.key_sel == `CKL_SEL_ROOT) begin
         next_m.key = root_key;
      end else if (cfg.key_sel == `CKL_SEL_SECONDARY) begin
         next_m.key = cfg.lock ? '0 : secondary_hw_key;
      end else begin
         next_m.key = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         m <= '0;
      end else begin
         m <= next_m;
      end
   end

   assign aes_key = m.key;

endmodule // ckl_key_mux

`default_nettype wire

// file: ckl_regs.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

// How it works
// - Select register chooses the AES hardware key.
// - Lock set and select one give zeros.
// - Lock is write-once; secondary key then zeroed.
// - Root key words map to ascending 32-bit slices.
// - Reading root word zero returns retention status.
// - Lock and root words held until reset.
// - Lifecycle state accepts one write per reset.
// - Lifecycle encodings: zero debug, two secure.
// - Valid flag read-only, set once a documented state retained.
// - Root words rewritable in debug, once secure.
// - Retained status reads one only after retention.

module ckl_regs (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [`CKL_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [`CKL_KEY_W-1:0] secondary_hw_key,
   output logic [`CKL_KEY_W-1:0] aes_key
);

   logic rst_meta_n;
   logic rst_sync_n;

   // Only the release is synchronised; assertion stays asynchronous.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   ckl_pkg::ckl_bus_req_t bus;
   ckl_pkg::ckl_regs_state_t s;
   ckl_pkg::ckl_regs_state_t next_s;
   ckl_pkg::ckl_key_cfg_t key_cfg;

   assign bus.addr = reg_addr;
   assign bus.wdata = reg_wdata;
   assign bus.wr = reg_wr;
   assign bus.rd = reg_rd;

   logic hit_enable;
   logic hit_sel;
   logic hit_lock;
   logic hit_lcs;
   logic secure_mode;
   logic lcs_valid;
   logic [`CKL_KEY_WORDS-1:0] hit_word;
   logic [`CKL_KEY_WORDS-1:0] word_open;

   assign hit_enable = bus.wr && (bus.addr == `CKL_OFS_ENABLE);
   assign hit_sel = bus.wr && (bus.addr == `CKL_OFS_KEY_SEL);
   assign hit_lock = bus.wr && (bus.addr == `CKL_OFS_KEY_LOCK);
   assign hit_lcs = bus.wr && (bus.addr == `CKL_OFS_LCS);
   assign secure_mode = (s.lifecycle_state == `CKL_LCS_SECURE);

   // A state that is neither documented code never counts as valid.
   assign lcs_valid = s.lcs_written &&
      ((s.lifecycle_state == `CKL_LCS_DEBUG) || (s.lifecycle_state == `CKL_LCS_SECURE));

   genvar gi;
   generate
      for (gi = 0; gi < `CKL_KEY_WORDS; gi++) begin : g_word
         assign hit_word[gi] = bus.wr &&
            (bus.addr == 16'(`CKL_OFS_ROOT0 + gi * `CKL_WORD_STEP));
         // In secure mode each word takes its first write only.
         assign word_open[gi] = !(secure_mode && s.word_written[gi]);
      end
   endgenerate

   always_comb begin
      next_s = s;
      next_s.rdata = '0;

      if (hit_enable) begin
         next_s.enable = bus.wdata[`CKL_ENABLE_POS];
      end
      if (hit_sel) begin
         next_s.key_sel = bus.wdata[`CKL_SEL_W-1:0];
      end

      // The first write consumes the lock even if it writes zero.
      if (hit_lock && !s.lock_used) begin
         next_s.lock_set = bus.wdata[`CKL_LOCK_POS];
         next_s.lock_used = 1'b1;
      end

      for (int i = 0; i < `CKL_KEY_WORDS; i++) begin
         if (hit_word[i] && word_open[i]) begin
            next_s.root_key[i] = bus.wdata;
            next_s.word_written[i] = 1'b1;
         end
      end

      // Retention completes one cycle after the last word lands.
      if (&s.word_written) begin
         next_s.retained = 1'b1;
      end

      if (hit_lcs && !s.lcs_written) begin
         next_s.lifecycle_state = bus.wdata[`CKL_LCS_W-1:0];
         next_s.lcs_written = 1'b1;
      end

      if (bus.rd) begin
         unique case (bus.addr)
            `CKL_OFS_ENABLE: begin
               next_s.rdata[`CKL_ENABLE_POS] = s.enable;
            end
            `CKL_OFS_KEY_SEL: begin
               next_s.rdata[`CKL_SEL_W-1:0] = s.key_sel;
            end
            `CKL_OFS_KEY_LOCK: begin
               next_s.rdata[`CKL_LOCK_POS] = s.lock_set;
            end
            `CKL_OFS_ROOT0: begin
               next_s.rdata[`CKL_RETAINED_POS] = s.retained;
            end
            `CKL_OFS_LCS: begin
               next_s.rdata[`CKL_LCS_W-1:0] = s.lifecycle_state;
               next_s.rdata[`CKL_LCS_VALID_POS] = lcs_valid;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end
   end

   // Key material and the lock are cleared only by reset, modelling
   // the always-on retention of the real subsystem.
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s <= '{
            enable: `CKL_RST_ENABLE,
            key_sel: `CKL_RST_SEL,
            lifecycle_state: `CKL_RST_LCS,
            default: '0
         };
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;

   assign key_cfg.enable = s.enable;
   assign key_cfg.key_sel = s.key_sel;
   assign key_cfg.lock = s.lock_set;

   ckl_key_mux u_key_mux (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .cfg(key_cfg),
      .root_key(s.root_key),
      .secondary_hw_key(secondary_hw_key),
      .aes_key(aes_key)
   );

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_sync_n);

   sequence lcs_wr_s;
      bus.wr && (bus.addr == `CKL_OFS_LCS);
   endsequence

   sequence lock_wr_s;
      bus.wr && (bus.addr == `CKL_OFS_KEY_LOCK);
   endsequence

   sequence root0_rd_s;
      bus.rd && (bus.addr == `CKL_OFS_ROOT0);
   endsequence

   sequence lcs_rd_s;
      bus.rd && (bus.addr == `CKL_OFS_LCS);
   endsequence

   sequence all_words_s;
      &s.word_written;
   endsequence

   lcs_once_a: assert property (
      s.lcs_written ##0 lcs_wr_s |=> $stable(s.lifecycle_state)
   ) else $error("lifecycle state changed after its one write");

   lcs_first_a: assert property (
      !s.lcs_written ##0 lcs_wr_s
      |=> s.lifecycle_state == $past(bus.wdata[`CKL_LCS_W-1:0]) && s.lcs_written
   ) else $error("first lifecycle write not stored");

   lcs_valid_rd_a: assert property (
      lcs_rd_s |=> reg_rdata[`CKL_LCS_VALID_POS] == $past(lcs_valid)
   ) else $error("valid flag read back wrong");

   lcs_valid_enc_a: assert property (
      lcs_rd_s ##1 reg_rdata[`CKL_LCS_VALID_POS]
      |-> (reg_rdata[`CKL_LCS_W-1:0] == 3'h0) || (reg_rdata[`CKL_LCS_W-1:0] == 3'h2)
   ) else $error("valid flag set for an undefined lifecycle code");

   lock_once_a: assert property (
      s.lock_used ##0 lock_wr_s |=> $stable(s.lock_set) [*2]
   ) else $error("key lock changed after its one write");

   lock_kept_a: assert property (
      s.lock_set |=> s.lock_set
   ) else $error("key lock lost before reset");

   root_secure_a: assert property (
      secure_mode && s.word_written[0] && hit_word[0]
      |=> $stable(s.root_key[0])
   ) else $error("secure root word accepted a second write");

   root_debug_a: assert property (
      !secure_mode && hit_word[3]
      |=> s.root_key[3] == $past(bus.wdata)
   ) else $error("debug root word write ignored");

   retained_rd_a: assert property (
      root0_rd_s |=> reg_rdata == {31'h0, $past(s.retained)}
   ) else $error("root word zero read returned key material");

   retained_cause_a: assert property (
      $rose(s.retained) |-> $past(s.word_written) == 4'hF
   ) else $error("retention reported before all words written");

   retained_time_a: assert property (
      all_words_s ##0 !s.retained |=> s.retained
   ) else $error("retention not reported one cycle after last word");

   rdata_pulse_a: assert property (
      !bus.rd |=> reg_rdata == 32'h0
   ) else $error("read data present without a read");

   key_zero_a: assert property (
      s.enable && s.lock_set && (s.key_sel == 2'h1)
      |=> aes_key == '0
   ) else $error("secondary key reached the engine while locked");

   key_root_a: assert property (
      s.enable && (s.key_sel == 2'h0)
      |=> aes_key == $past(s.root_key)
   ) else $error("root key not routed to the engine");

   key_word_map_a: assert property (
      s.enable && (s.key_sel == 2'h0)
      |=> aes_key[127:96] == $past(s.root_key[3])
         && aes_key[31:0] == $past(s.root_key[0])
   ) else $error("root key words in the wrong slices");

   key_second_a: assert property (
      s.enable && !s.lock_set && (s.key_sel == 2'h1)
      |=> aes_key == $past(secondary_hw_key)
   ) else $error("secondary key not routed while unlocked");

   // Read-back checks look one cycle after the strobe, where the data stand.
   sequence sel_rd_s;
      bus.rd && (bus.addr == `CKL_OFS_KEY_SEL);
   endsequence

   sequence lock_rd_s;
      bus.rd && (bus.addr == `CKL_OFS_KEY_LOCK);
   endsequence

   sequence high_word_rd_s;
      bus.rd && ((bus.addr == `CKL_OFS_ROOT1) || (bus.addr == `CKL_OFS_ROOT2)
         || (bus.addr == `CKL_OFS_ROOT3));
   endsequence

   sequence no_word_wr_s;
      !(|hit_word);
   endsequence

   lock_first_a: assert property (
      !s.lock_used ##0 lock_wr_s
      |=> s.lock_used && (s.lock_set == $past(bus.wdata[`CKL_LOCK_POS]))
   ) else $error("first key lock write not stored");

   lock_rd_a: assert property (
      lock_rd_s |=> reg_rdata == {31'h0, $past(s.lock_set)}
   ) else $error("key lock read back wrong");

   sel_rd_a: assert property (
      sel_rd_s |=> reg_rdata == {30'h0, $past(s.key_sel)}
   ) else $error("key select read back wrong");

   high_words_a: assert property (
      high_word_rd_s |=> reg_rdata == 32'h0
   ) else $error("write-only root word returned key material");

   root_kept_a: assert property (
      no_word_wr_s |=> $stable(s.root_key)
   ) else $error("root key changed without a write");

   retained_kept_a: assert property (
      s.retained |=> s.retained
   ) else $error("retention status lost before reset");

   lcs_kept_a: assert property (
      s.lcs_written |=> s.lcs_written && $stable(s.lifecycle_state)
   ) else $error("lifecycle state lost before reset");

   lcs_rd_bits_a: assert property (
      lcs_rd_s |=> reg_rdata[`CKL_LCS_W-1:0] == $past(s.lifecycle_state)
   ) else $error("lifecycle state read back wrong");

   valid_early_a: assert property (
      lcs_rd_s ##0 !s.lcs_written |=> !reg_rdata[`CKL_LCS_VALID_POS]
   ) else $error("valid flag set before any lifecycle write");

   valid_set_a: assert property (
      lcs_rd_s ##0 (s.lcs_written && ((s.lifecycle_state == 3'h0) || (s.lifecycle_state == 3'h2)))
      |=> reg_rdata[`CKL_LCS_VALID_POS]
   ) else $error("valid flag clear after a valid lifecycle write");

   key_off_a: assert property (
      !s.enable |=> aes_key == '0
   ) else $error("key reached the engine while disabled");

   key_sel_high_a: assert property (
      s.key_sel[1] |=> aes_key == '0
   ) else $error("undefined key select reached the engine");

   // Each root word gets the same pair of write checks.
   genvar gk;
   generate
      for (gk = 0; gk < `CKL_KEY_WORDS; gk++) begin : g_word_chk
         root_once_a: assert property (
            secure_mode && s.word_written[gk] && hit_word[gk]
            |=> $stable(s.root_key[gk])
         ) else $error("secure root word took a second write");

         root_store_a: assert property (
            hit_word[gk] && (!secure_mode || !s.word_written[gk])
            |=> s.root_key[gk] == $past(bus.wdata)
         ) else $error("open root word write not stored");
      end
   endgenerate

endmodule // ckl_regs

`default_nettype wire

// file: ckl_aes_sink.sv
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

// The engine latches the hardware key on every rising edge. It never loads the key bus back,
// so a stale or zero key shows up here one cycle after the register block drives it.
module ckl_aes_sink (
   input wire logic sys_clk,
   input wire logic [`CKL_KEY_W-1:0] aes_key,
   output logic [`CKL_KEY_W-1:0] key_in_use
);
   always_ff @(posedge sys_clk) begin
      key_in_use <= aes_key;
   end
endmodule // ckl_aes_sink

`default_nettype wire

// file: crypto_key_lifecycle_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ckl_cfg.svh"

module crypto_key_lifecycle_regs_tb_top;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   ckl_pkg::ckl_bus_req_t req = '0;
   logic [31:0] reg_rdata;
   logic [127:0] sec_key = '0;
   logic [127:0] aes_key;
   logic [127:0] key_in_use;
   logic [127:0] rk;
   logic [31:0] exp_q[$];
   logic rd_d = 1'b0;
   int fail_count = 0;
   int comparisons = 0;
   int seed = 98;

   always #10 sys_clk = ~sys_clk;

   ckl_regs dut_u (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reg_addr(req.addr),
      .reg_wdata(req.wdata),
      .reg_wr(req.wr),
      .reg_rd(req.rd),
      .reg_rdata(reg_rdata),
      .secondary_hw_key(sec_key),
      .aes_key(aes_key)
   );

   ckl_aes_sink sink_u (
      .sys_clk(sys_clk),
      .aes_key(aes_key),
      .key_in_use(key_in_use)
   );

   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // The expected word is queued here and consumed by the read monitor.
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      req.wdata <= $random(seed);
      exp_q.push_back(exp);
      @(posedge sys_clk);
      req.rd <= 1'b0;
   endtask

   // Two edges inside the block plus one in the engine model, with one spare.
   task automatic kchk(input logic [127:0] exp);
      repeat (4) @(posedge sys_clk);
      chk("aes_key", key_in_use, exp);
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic load_root();
      for (int i = 0; i < 4; i++) begin
         rk[i*32+:32] = $random(seed);
         wr(`CKL_OFS_ROOT0 + 16'(i * 4), rk[i*32+:32]);
      end
   endtask

   task final_report;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (rd_d) begin
         chk("reg_rdata", {96'h0, reg_rdata}, {96'h0, exp_q.pop_front()});
      end
      rd_d <= req.rd;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      final_report();
   end

   initial begin
      do_reset();
      rd(`CKL_OFS_LCS, 32'h0000_0002);
      rd(`CKL_OFS_ROOT0, 32'h0);
      rd(16'h0504, 32'h0);
      kchk(128'h0);
      wr(`CKL_OFS_LCS, 32'h0);
      rd(`CKL_OFS_LCS, 32'h0000_0100);
      wr(`CKL_OFS_LCS, 32'h2);
      rd(`CKL_OFS_LCS, 32'h0000_0100);
      $display("lifecycle test done");
      wr(`CKL_OFS_ENABLE, 32'h1);
      load_root();
      rd(`CKL_OFS_ROOT0, 32'h1);
      rd(`CKL_OFS_ROOT1, 32'h0);
      kchk(rk);
      rk[31:0] = ~rk[31:0];
      wr(`CKL_OFS_ROOT0, rk[31:0]);
      kchk(rk);
      sec_key <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      wr(`CKL_OFS_KEY_SEL, 32'h1);
      rd(`CKL_OFS_KEY_SEL, 32'h1);
      rd(`CKL_OFS_ENABLE, 32'h1);
      kchk(sec_key);
      wr(`CKL_OFS_KEY_LOCK, 32'h1);
      kchk(128'h0);
      wr(`CKL_OFS_KEY_LOCK, 32'h0);
      rd(`CKL_OFS_KEY_LOCK, 32'h1);
      kchk(128'h0);
      wr(`CKL_OFS_KEY_SEL, 32'h0);
      kchk(rk);
      wr(`CKL_OFS_KEY_SEL, 32'h2);
      kchk(128'h0);
      wr(`CKL_OFS_KEY_SEL, 32'h3);
      kchk(128'h0);
      wr(`CKL_OFS_KEY_SEL, 32'h0);
      wr(`CKL_OFS_ENABLE, 32'h0);
      rd(`CKL_OFS_ENABLE, 32'h0);
      kchk(128'h0);
      $display("key path test done");
      do_reset();
      rd(`CKL_OFS_KEY_LOCK, 32'h0);
      wr(`CKL_OFS_LCS, 32'h2);
      rd(`CKL_OFS_LCS, 32'h0000_0102);
      wr(`CKL_OFS_ENABLE, 32'h1);
      load_root();
      wr(`CKL_OFS_ROOT0, ~rk[31:0]);
      rd(`CKL_OFS_ROOT0, 32'h1);
      kchk(rk);
      wr(`CKL_OFS_KEY_SEL, 32'h1);
      kchk(sec_key);
      $display("secure mode test done");
      // An undefined lifecycle code is stored but never reported as valid.
      do_reset();
      wr(`CKL_OFS_LCS, 32'h1);
      rd(`CKL_OFS_LCS, 32'h0000_0001);
      $display("invalid state test done");
      final_report();
   end
endmodule // crypto_key_lifecycle_regs_tb_top

`default_nettype wire
